/* File: pkg/bmc_defs.vh */
// constants for the battery mode controller
// assumes inclusion by bare name from design files
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH
`define BMC_REQ_DISPLAY_BIT 6
`define BMC_REQ_SLEEP_BIT 7
`define BMC_BOOST_PLL_ON 2'b10
`define BMC_WAKE_NONE 7'h00
`define BMC_WAKE_TIMER 0
`define BMC_WAKE_BUTTON 1
`define BMC_WAKE_PIN4 2
`define BMC_WAKE_PIN52 3
`define BMC_WAKE_PIN55 4
`define BMC_WAKE_SERIAL 5
`define BMC_WAKE_OPTICAL 6
`define BMC_WAKE_BITS 7
`define BMC_SYNC_SETTLE 2'h2
`endif

/* File: verilog/bmc_sync.v */
// two-stage synchroniser bank
// assumes asynchronous level inputs, one destination clock
`timescale 1ns/1ns
module bmc_sync
#(
  parameter WIDTH = 8
)
(
  input wire clk,
  input wire reset,
  input wire clkEnable,
  input wire [WIDTH-1:0] asyncIn,
  output wire [WIDTH-1:0] syncOut
);
  reg [WIDTH-1:0] stage1_reg;
  reg [WIDTH-1:0] stage2_reg;
  // first stage feeds only the second
  always @(posedge clk)
  begin
    if (reset)
    begin
      stage1_reg <= {WIDTH{1'b0}};
      stage2_reg <= {WIDTH{1'b0}};
    end
    else if (clkEnable)
    begin
      stage1_reg <= asyncIn;
      stage2_reg <= stage1_reg;
    end
  end
  assign syncOut = stage2_reg;
endmodule

/* File: verilog/bmc_mode_ctrl.v */
// operating-mode controller: mission, brownout, display-only, sleep
// assumes always-on clock; comparator and wake pins are asynchronous
`timescale 1ns/1ns
`include "bmc_defs.vh"
module bmc_mode_ctrl
(
  input wire clk,
  input wire reset,
  input wire clkEnable,
  input wire supplyComparatorLow,
  input wire systemPowerPresent,
  input wire pllStable,
  input wire [7:0] modeRequest,
  input wire [1:0] displayBoostSelect,
  input wire wakeTimerTimeout,
  input wire pushbuttonInput,
  input wire sharedPin4,
  input wire sharedPin52,
  input wire sharedPin55,
  input wire serialReceivePin,
  input wire opticalReceivePin,
  input wire wakeCauseClear,
  output reg missionMode,
  output reg brownoutMode,
  output reg displayOnlyMode,
  output reg sleepMode,
  output reg supplyOkFlag,
  output reg systemResourcesEnable,
  output reg batterySupplySelect,
  output reg pllEnable,
  output reg processorReset,
  output reg [6:0] wakeCause
);
  localparam ST_START = 5'b00001;
  localparam ST_MISSION = 5'b00010;
  localparam ST_BROWNOUT = 5'b00100;
  localparam ST_DISPLAY = 5'b01000;
  localparam ST_SLEEP = 5'b10000;

  reg [4:0] state_reg;
  reg [4:0] state_next;
  reg pin4Prev_reg;
  reg serialPrev_reg;
  reg opticalPrev_reg;
  reg [6:0] wakeCause_next;
  wire [7:0] syncBits;
  wire supplyGood;
  wire powerGood;
  wire [6:0] wakeEvents;
  wire anyWake;
  reg [1:0] settle_reg;
  wire settled;

  bmc_sync #(.WIDTH(8)) inputSync
  (
    .clk(clk),
    .reset(reset),
    .clkEnable(clkEnable),
    .asyncIn({~supplyComparatorLow, wakeTimerTimeout, pushbuttonInput,
      sharedPin4, sharedPin52, sharedPin55, serialReceivePin,
      opticalReceivePin}),
    .syncOut(syncBits)
  );

  // receive lines idle at either level, so any change is activity
  function rx_activity;
    input now;
    input prev;
    begin
      rx_activity = now ^ prev;
    end
  endfunction

  assign supplyGood = syncBits[7];
  assign powerGood = systemPowerPresent & supplyGood;

  assign wakeEvents[`BMC_WAKE_TIMER] = syncBits[6];
  assign wakeEvents[`BMC_WAKE_BUTTON] = syncBits[5];
  // pin 4 edge, pins 52 and 55 level
  assign wakeEvents[`BMC_WAKE_PIN4] = syncBits[4] & ~pin4Prev_reg;
  assign wakeEvents[`BMC_WAKE_PIN52] = syncBits[3];
  assign wakeEvents[`BMC_WAKE_PIN55] = syncBits[2];
  assign wakeEvents[`BMC_WAKE_SERIAL] =
    rx_activity(syncBits[1], serialPrev_reg);
  assign wakeEvents[`BMC_WAKE_OPTICAL] =
    rx_activity(syncBits[0], opticalPrev_reg);
  assign anyWake = |wakeEvents;
  // sync stages read zero until filled, else a false brownout
  assign settled = settle_reg == `BMC_SYNC_SETTLE;

  always @*
  begin
    state_next = state_reg;
    wakeCause_next = wakeCause;
    if (wakeCauseClear)
      wakeCause_next = `BMC_WAKE_NONE;
    case (state_reg)
      ST_START:
      begin
        if (!settled)
          state_next = ST_START;
        else if (powerGood & pllStable)
          state_next = ST_MISSION;
        else if (!powerGood)
          state_next = ST_BROWNOUT;
      end
      ST_MISSION:
      begin
        if (!powerGood)
          state_next = ST_BROWNOUT;
        else if (modeRequest[`BMC_REQ_DISPLAY_BIT])
          state_next = ST_MISSION;
      end
      ST_BROWNOUT:
      begin
        if (powerGood)
          state_next = ST_MISSION;
        // requests only honoured here
        // a request left set re-enters straight after a wake
        // sleep has priority
        else if (modeRequest[`BMC_REQ_SLEEP_BIT])
          state_next = ST_SLEEP;
        else if (modeRequest[`BMC_REQ_DISPLAY_BIT])
          state_next = ST_DISPLAY;
      end
      ST_DISPLAY, ST_SLEEP:
      begin
        if (powerGood)
          state_next = ST_MISSION;
        else if (anyWake)
          state_next = ST_BROWNOUT;
        // capture cause, set wins over clear
        if (!powerGood && anyWake)
          wakeCause_next = wakeEvents;
      end
      default:
        state_next = ST_START;
    endcase
  end

  always @(posedge clk)
  begin
    if (reset)
    begin
      state_reg <= ST_START;
      settle_reg <= 2'h0;
      // edge history starts at the synchroniser reset level
      pin4Prev_reg <= 1'b0;
      serialPrev_reg <= 1'b0;
      opticalPrev_reg <= 1'b0;
      wakeCause <= `BMC_WAKE_NONE;
      missionMode <= 1'b0;
      brownoutMode <= 1'b0;
      displayOnlyMode <= 1'b0;
      sleepMode <= 1'b0;
      supplyOkFlag <= 1'b0;
      systemResourcesEnable <= 1'b0;
      batterySupplySelect <= 1'b0;
      pllEnable <= 1'b1;
      processorReset <= 1'b0;
    end
    else if (clkEnable)
    begin
      state_reg <= state_next;
      if (!settled)
        settle_reg <= settle_reg + 2'h1;
      pin4Prev_reg <= syncBits[4];
      serialPrev_reg <= syncBits[1];
      opticalPrev_reg <= syncBits[0];
      wakeCause <= wakeCause_next;
      missionMode <= state_next == ST_MISSION;
      brownoutMode <= state_next == ST_BROWNOUT;
      displayOnlyMode <= state_next == ST_DISPLAY;
      sleepMode <= state_next == ST_SLEEP;
      supplyOkFlag <= supplyGood;
      systemResourcesEnable <= state_next == ST_MISSION;
      // battery feeds every mode but mission and start
      batterySupplySelect <= state_next != ST_MISSION &&
        state_next != ST_START;
      // display-only pll needs boost select 10
      pllEnable <= state_next == ST_SLEEP ? 1'b0 :
        state_next == ST_DISPLAY ?
        displayBoostSelect == `BMC_BOOST_PLL_ON : 1'b1;
      // processor never reset by mode changes
      processorReset <= 1'b0;
    end
  end
endmodule

/* File: dv/bmc_supply_model.sv */
// supply comparator and power pin model
// assumes powerOn is the board supply switch
`timescale 1ns/1ns
module bmc_supply_model
(
  input wire clk,
  input wire powerOn,
  output reg systemPowerPresent,
  output reg supplyComparatorLow
);
  always @(posedge clk)
  begin
    systemPowerPresent <= powerOn;
    supplyComparatorLow <= !powerOn;
  end
endmodule

/* File: dv/bmc_mode_ctrl_props.sv */
// port assertions for the mode controller
// assumes one clock, sync active-high reset
`timescale 1ns/1ns
module bmc_mode_ctrl_props
(
  input wire clk,
  input wire reset,
  input wire systemPowerPresent,
  input wire pllStable,
  input wire [1:0] displayBoostSelect,
  input wire supplyOkFlag,
  input wire missionMode,
  input wire brownoutMode,
  input wire displayOnlyMode,
  input wire sleepMode,
  input wire systemResourcesEnable,
  input wire batterySupplySelect,
  input wire pllEnable,
  input wire processorReset
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);
  res_mission_a: assert property (
    systemResourcesEnable == missionMode) else $error("res");
  bat_select_a: assert property (
    batterySupplySelect == (brownoutMode || displayOnlyMode || sleepMode))
    else $error("bat");
  cpu_run_a: assert property (!processorReset) else $error("cpu");
  pll_kept_a: assert property (
    brownoutMode |-> pllEnable) else $error("pll brn");
  // previous edge settled the boost choice
  pll_boost_a: assert property (
    displayOnlyMode && $past(displayOnlyMode) && $stable(displayBoostSelect)
    |-> pllEnable == (displayBoostSelect == 2'b10)) else $error("pll");
  entry_brn_a: assert property (
    $rose(displayOnlyMode || sleepMode) |-> $past(brownoutMode))
    else $error("entry");
  force_brn_a: assert property (
    (!systemPowerPresent) [*3] |-> !missionMode) else $error("force");
  back_msn_a: assert property (
    (systemPowerPresent && supplyOkFlag && pllStable) [*3] |-> missionMode)
    else $error("msn");
  cover property ($rose(sleepMode));
  cover property ($rose(displayOnlyMode));
  cover property ($fell(displayOnlyMode) && brownoutMode);
endmodule
bind bmc_mode_ctrl bmc_mode_ctrl_props props (.*);

/* File: dv/test_battery_mode_controller.sv */
// self-checking bench for the mode controller
// assumes supply model and bound checker
`timescale 1ns/1ns
module test_battery_mode_controller;
  reg clk = 0;
  reg reset = 1;
  reg pwr = 0;
  reg clr = 0;
  reg [7:0] req = 8'h00;
  reg [1:0] boost = 2'h0;
  reg [6:0] wk = 7'h00;
  reg ce = 1;
  reg pllOk = 1;
  reg [11:0] rows [0:7];
  wire sysPwr, cmpLow, m, b, d, s, okF, res, bat, pll, cpuRst;
  wire [6:0] cause;
  integer n_fail = 0;
  integer compares = 0;
  integer cycles = 0;
  integer i;
  initial forever #5 clk = ~clk;
  bmc_supply_model sup (.clk(clk), .powerOn(pwr),
    .systemPowerPresent(sysPwr), .supplyComparatorLow(cmpLow));
  bmc_mode_ctrl uut (.clk(clk), .reset(reset), .clkEnable(ce),
    .supplyComparatorLow(cmpLow), .systemPowerPresent(sysPwr),
    .pllStable(pllOk), .modeRequest(req), .displayBoostSelect(boost),
    .wakeTimerTimeout(wk[0]), .pushbuttonInput(wk[1]),
    .sharedPin4(wk[2]), .sharedPin52(wk[3]), .sharedPin55(wk[4]),
    .serialReceivePin(wk[5]), .opticalReceivePin(wk[6]),
    .wakeCauseClear(clr), .missionMode(m), .brownoutMode(b),
    .displayOnlyMode(d), .sleepMode(s), .supplyOkFlag(okF),
    .systemResourcesEnable(res), .batterySupplySelect(bat),
    .pllEnable(pll), .processorReset(cpuRst), .wakeCause(cause));
  task chk(input [47:0] nm, input [6:0] g, input [6:0] e);
  begin
    compares = compares + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("ERROR %0s exp %h got %h", nm, e, g);
    end
  end
  endtask
  task tally_and_finish;
  begin
    $display("checks %0d fails %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  end
  endtask
  // run takes about 223 cycles
  always @(posedge clk)
  begin
    cycles = cycles + 1;
    if (cycles == 1500)
    begin
      n_fail = n_fail + 1;
      tally_and_finish;
    end
  end
  initial
  begin
    // pwr sleep disp boost, then mode m b d s and pll
    rows[0] = 12'h811;
    rows[1] = 12'hA11;
    rows[2] = 12'h009;
    rows[3] = 12'h305;
    rows[4] = 12'hB11;
    rows[5] = 12'h702;
    rows[6] = 12'h811;
    rows[7] = 12'h204;
    repeat (10) @(posedge clk);
    chk("rst", {m, b, d, s, pll, cpuRst, 1'b0}, 7'h04);
    chk("cause0", cause, 7'h00);
    $display("reset test done");
    reset <= 0;
    for (i = 0; i < 8; i = i + 1)
    begin
      pwr <= rows[i][11];
      req <= {rows[i][10:9], 6'h00};
      boost <= {rows[i][8], 1'b0};
      repeat (8) @(posedge clk);
      chk("mode", {okF, res, m, b, d, s, pll},
        {rows[i][11], rows[i][4], rows[i][4:0]});
      chk("bat", {6'h00, bat}, {6'h00, |rows[i][3:1]});
    end
    $display("mode rows done");
    // request dropped first, else display-only again
    for (i = 0; i < 7; i = i + 1)
    begin
      req <= 8'h40;
      repeat (6) @(posedge clk);
      req <= 8'h00;
      wk <= 7'h01 << i;
      repeat (6) @(posedge clk);
      chk("wake", {6'h00, b}, 7'h01);
      chk("cause", cause, 7'h01 << i);
      wk <= 7'h00;
      clr <= 1;
      @(posedge clk);
      clr <= 0;
      repeat (4) @(posedge clk);
    end
    $display("wake tests done");
    // frozen clock enable must hold brownout
    ce <= 0;
    req <= 8'h80;
    repeat (4) @(posedge clk);
    chk("frozen", {6'h00, b}, 7'h01);
    ce <= 1;
    repeat (3) @(posedge clk);
    chk("sleep", {6'h00, s}, 7'h01);
    req <= 8'h00;
    pwr <= 1;
    repeat (8) @(posedge clk);
    chk("msn", {6'h00, m}, 7'h01);
    req <= 8'h80;
    repeat (3) @(posedge clk);
    chk("refuse", {6'h00, m}, 7'h01);
    // soft reset after return to mission
    reset <= 1;
    pllOk <= 0;
    repeat (3) @(posedge clk);
    reset <= 0;
    repeat (6) @(posedge clk);
    chk("start", {5'h00, m, b}, 7'h00);
    pllOk <= 1;
    repeat (3) @(posedge clk);
    chk("pll", {5'h00, m, b}, 7'h02);
    $display("awkward tests done");
    tally_and_finish;
  end
endmodule
